// ==== design/mcsr_top.v ====
// Purpose: PHY calibration/clock control and controller configuration registers
// Assumes: AXI4-Lite master, one write and one read at a time; single clock
// Notes: Registers at index 0x100, 0x110, 0x140 and 0x141, byte address four times index
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ns
`include "mcsr_defs.vh"
module mcsr_top #(
    parameter [15:0] PD_CNT_RST = `MCSR_PD_CNT_RST, // Idle count reset value
    parameter [1:0] RATE_CODE = `MCSR_RATE_HALF     // Controller data rate
) (
    input wire clk,                     // 100 MHz clock
    input wire rst_n,                   // Synchronous reset, active low
    input wire [13:0] s_axi_awaddr,     // Write address
    input wire s_axi_awvalid,           // Write address valid
    output reg s_axi_awready,           // Write address ready
    input wire [31:0] s_axi_wdata,      // Write data
    input wire [3:0] s_axi_wstrb,       // Write byte strobes
    input wire s_axi_wvalid,            // Write data valid
    output reg s_axi_wready,            // Write data ready
    output reg [1:0] s_axi_bresp,       // Write response
    output reg s_axi_bvalid,            // Write response valid
    input wire s_axi_bready,            // Write response ready
    input wire [13:0] s_axi_araddr,     // Read address
    input wire s_axi_arvalid,           // Read address valid
    output reg s_axi_arready,           // Read address ready
    output reg [31:0] s_axi_rdata,      // Read data
    output reg [1:0] s_axi_rresp,       // Read response
    output reg s_axi_rvalid,            // Read data valid
    input wire s_axi_rready,            // Read data ready
    input wire phy_cal_success,         // PHY calibration success level
    input wire phy_cal_fail,            // PHY calibration failure level
    output reg phy_cal_req,             // Calibration request to PHY
    output reg [5:0] mem_clk_disable,   // Per-clock disable to PHY
    input wire ctl_queue_empty,         // Controller command queue empty
    input wire local_self_rfsh_req,     // Local self-refresh request
    input wire mem_in_powerdown,        // Memory is in power-down
    input wire mem_in_self_refresh,     // Memory is in self-refresh
    output reg powerdown_req,           // Power-down entry request
    output reg self_refresh_req,        // Self-refresh entry request
    output reg [1:0] addr_order,        // Local address split order
    output reg registered_module_enable, // Registered module support
    output reg irq                      // Level interrupt
);
    // ==========================================================
    // Decoding shared by read and write paths
    function [2:0] reg_sel;
        input [13:0] a;
        begin
            case (a)
                `MCSR_ADDR_PHY: reg_sel = 3'h1;
                `MCSR_ADDR_CFG: reg_sel = 3'h2;
                `MCSR_ADDR_IRQ_STAT: reg_sel = 3'h3;
                `MCSR_ADDR_IRQ_MASK: reg_sel = 3'h4;
                default: reg_sel = 3'h0;
            endcase
        end
    endfunction

    // ==========================================================
    // Status inputs from outside the clock domain
    wire [3:0] sync_q;
    wire cal_ok_s;
    wire cal_fail_s;
    wire pd_s;
    wire sr_s;

    mcsr_sync #(
        .W(4)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d({mem_in_self_refresh, mem_in_powerdown, phy_cal_fail, phy_cal_success}),
        .q(sync_q)
    );
    assign cal_ok_s = sync_q[0];
    assign cal_fail_s = sync_q[1];
    assign pd_s = sync_q[2];
    assign sr_s = sync_q[3];

    // Self-refresh request input also comes from another clock's logic
    reg sr_in_meta_r;
    reg sr_in_r;

    always @(posedge clk) begin
        if (!rst_n) begin
            sr_in_meta_r <= 1'b0;
            sr_in_r <= 1'b0;
        end else begin
            sr_in_meta_r <= local_self_rfsh_req;
            sr_in_r <= sr_in_meta_r;
        end
    end

    // ==========================================================
    // Software registers
    reg [15:0] idle_powerdown_count_r;
    reg sr_bit_r;
    reg [`MCSR_IRQ_W-1:0] irq_stat_r;
    reg [`MCSR_IRQ_W-1:0] irq_mask_r;
    reg [3:0] prev_r;
    wire pd_req_w;

    mcsr_pd_timer #(
        .W(16)
    ) u_pd_timer (
        .clk(clk),
        .rst_n(rst_n),
        .idle(ctl_queue_empty),
        .limit(idle_powerdown_count_r),
        .pd_req(pd_req_w)
    );

    // ==========================================================
    // Write channel: address and data taken in either order
    reg [13:0] waddr_r;
    reg aw_held_r;
    reg [31:0] wdata_r;
    reg [3:0] wstrb_r;
    reg w_held_r;
    wire do_write;
    wire [31:0] mask32;
    wire [31:0] wd;
    wire [2:0] wsel;

    assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
    assign mask32 = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
    assign wd = wdata_r & mask32;
    assign wsel = reg_sel(waddr_r);

    // Events seen this cycle; rising edges of synchronised status
    wire [`MCSR_IRQ_W-1:0] ev;
    assign ev = {sr_s & ~prev_r[3], pd_s & ~prev_r[2], cal_fail_s & ~prev_r[1],
                 cal_ok_s & ~prev_r[0]};

    always @(posedge clk) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `MCSR_RESP_OKAY;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            waddr_r <= 14'h0000;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
            phy_cal_req <= 1'b0;
            mem_clk_disable <= 6'h00;
            idle_powerdown_count_r <= PD_CNT_RST;
            sr_bit_r <= 1'b0;
            addr_order <= `MCSR_ORD_CRBC;
            registered_module_enable <= 1'b0;
            irq_stat_r <= {`MCSR_IRQ_W{1'b0}};
            irq_mask_r <= {`MCSR_IRQ_W{1'b0}};
            prev_r <= 4'h0;
        end else begin
            prev_r <= {sr_s, pd_s, cal_fail_s, cal_ok_s};
            // Ready pulses one cycle when a beat is offered and the slot is free
            s_axi_awready <= s_axi_awvalid && !aw_held_r && !s_axi_awready;
            s_axi_wready <= s_axi_wvalid && !w_held_r && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                waddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            irq_stat_r <= irq_stat_r | ev;
            if (do_write) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wsel == 3'h0) ? `MCSR_RESP_SLVERR : `MCSR_RESP_OKAY;
                case (wsel)
                    3'h1: begin
                        // Bits 0, 1 and reserved bits ignore writes
                        if (wstrb_r[0]) begin
                            phy_cal_req <= wd[`MCSR_PHY_CAL_REQ_BIT];
                        end
                        if (wstrb_r[1]) begin
                            mem_clk_disable <= wd[13:8];
                        end
                    end
                    3'h2: begin
                        if (wstrb_r[0]) begin
                            idle_powerdown_count_r[7:0] <= wd[7:0];
                        end
                        if (wstrb_r[1]) begin
                            idle_powerdown_count_r[15:8] <= wd[15:8];
                        end
                        if (wstrb_r[2]) begin
                            sr_bit_r <= wd[`MCSR_CFG_SR_REQ_BIT];
                            addr_order <= wd[21:20];
                            registered_module_enable <= wd[`MCSR_CFG_REG_MOD_BIT];
                        end
                    end
                    3'h3: begin
                        // Write one to clear; a new event in the same cycle wins
                        if (wstrb_r[0]) begin
                            irq_stat_r <= (irq_stat_r & ~wd[`MCSR_IRQ_W-1:0]) | ev;
                        end
                    end
                    3'h4: begin
                        if (wstrb_r[0]) begin
                            irq_mask_r <= wd[`MCSR_IRQ_W-1:0];
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Read channel
    reg [31:0] rd_val;

    always @* begin
        rd_val = 32'h00000000; // Reserved bits stay zero
        case (reg_sel(s_axi_araddr))
            3'h1: begin
                rd_val[`MCSR_PHY_CAL_OK_BIT] = cal_ok_s;
                rd_val[`MCSR_PHY_CAL_FAIL_BIT] = cal_fail_s;
                rd_val[`MCSR_PHY_CAL_REQ_BIT] = phy_cal_req;
                rd_val[13:8] = mem_clk_disable;
            end
            3'h2: begin
                rd_val[15:0] = idle_powerdown_count_r;
                rd_val[`MCSR_CFG_PD_ACT_BIT] = pd_s;
                rd_val[`MCSR_CFG_SR_REQ_BIT] = sr_bit_r;
                rd_val[`MCSR_CFG_SR_ACT_BIT] = sr_s;
                rd_val[21:20] = addr_order;
                rd_val[`MCSR_CFG_REG_MOD_BIT] = registered_module_enable;
                rd_val[24:23] = RATE_CODE;
            end
            3'h3: begin
                rd_val[`MCSR_IRQ_W-1:0] = irq_stat_r;
            end
            3'h4: begin
                rd_val[`MCSR_IRQ_W-1:0] = irq_mask_r;
            end
            default: begin
                rd_val = 32'h00000000;
            end
        endcase
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `MCSR_RESP_OKAY;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_val;
                s_axi_rresp <= (reg_sel(s_axi_araddr) == 3'h0) ?
                    `MCSR_RESP_SLVERR : `MCSR_RESP_OKAY;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Outputs to the controller core and interrupt
    always @(posedge clk) begin
        if (!rst_n) begin
            powerdown_req <= 1'b0;
            self_refresh_req <= 1'b0;
            irq <= 1'b0;
        end else begin
            powerdown_req <= pd_req_w;
            self_refresh_req <= sr_bit_r | sr_in_r;
            irq <= |(irq_stat_r & irq_mask_r);
        end
    end
endmodule

// ==== design/mcsr_defs.vh ====
// Purpose: Constants for the memory controller PHY status and configuration registers
// Assumes: 32-bit AXI4-Lite register access, byte addresses
// Notes: Register indices are kept; byte address is four times the index
`ifndef MCSR_DEFS_VH
`define MCSR_DEFS_VH

// ==========================================================
// Register indices and byte addresses
`define MCSR_IDX_PHY 12'h100
`define MCSR_IDX_CFG 12'h110
`define MCSR_IDX_IRQ_STAT 12'h140
`define MCSR_IDX_IRQ_MASK 12'h141
`define MCSR_ADDR_W 14
`define MCSR_ADDR_PHY 14'h0400
`define MCSR_ADDR_CFG 14'h0440
`define MCSR_ADDR_IRQ_STAT 14'h0500
`define MCSR_ADDR_IRQ_MASK 14'h0504

// ==========================================================
// Physical-layer register fields
`define MCSR_PHY_CAL_OK_BIT 0
`define MCSR_PHY_CAL_FAIL_BIT 1
`define MCSR_PHY_CAL_REQ_BIT 2
`define MCSR_PHY_CLK_OFF_LSB 8
`define MCSR_PHY_CLK_OFF_W 6

// ==========================================================
// Controller configuration register fields
`define MCSR_CFG_PD_CNT_LSB 0
`define MCSR_CFG_PD_CNT_W 16
`define MCSR_CFG_PD_ACT_BIT 16
`define MCSR_CFG_SR_REQ_BIT 17
`define MCSR_CFG_SR_ACT_BIT 18
`define MCSR_CFG_ADDR_ORD_LSB 20
`define MCSR_CFG_REG_MOD_BIT 22
`define MCSR_CFG_RATE_LSB 23

// ==========================================================
// Field codes and reset values
`define MCSR_ORD_CRBC 2'h0
`define MCSR_ORD_CBRC 2'h1
`define MCSR_RATE_FULL 2'h0
`define MCSR_RATE_HALF 2'h1
`define MCSR_PD_CNT_RST 16'h0000

// ==========================================================
// Interrupt status bits
`define MCSR_IRQ_W 4
`define MCSR_IRQ_CAL_OK 0
`define MCSR_IRQ_CAL_FAIL 1
`define MCSR_IRQ_PD_ENTER 2
`define MCSR_IRQ_SR_ENTER 3

// ==========================================================
// AXI responses
`define MCSR_RESP_OKAY 2'h0
`define MCSR_RESP_SLVERR 2'h2

`endif

// ==== design/mcsr_sync.v ====
// Purpose: Two flip-flop synchroniser for a bus of levels
// Assumes: Inputs are quasi-static levels from another domain
// Notes: First stage is read only by the second stage
`timescale 1ns/1ns
module mcsr_sync #(
    parameter W = 2
) (
    input wire clk,            // Clock
    input wire rst_n,          // Synchronous reset, active low
    input wire [W-1:0] d,      // Asynchronous levels
    output reg [W-1:0] q       // Synchronised levels
);
    reg [W-1:0] meta_r;

    always @(posedge clk) begin
        if (!rst_n) begin
            meta_r <= {W{1'b0}};
            q <= {W{1'b0}};
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

// ==== design/mcsr_pd_timer.v ====
// Purpose: Idle counter that requests memory power-down
// Assumes: Idle level is on the controller clock
// Notes: A count of zero keeps the request low
`timescale 1ns/1ns
module mcsr_pd_timer #(
    parameter W = 16
) (
    input wire clk,            // Clock
    input wire rst_n,          // Synchronous reset, active low
    input wire idle,           // Command queue empty
    input wire [W-1:0] limit,  // Idle cycles before power-down
    output reg pd_req          // Power-down request level
);
    reg [W-1:0] cnt_r;

    always @(posedge clk) begin
        if (!rst_n) begin
            cnt_r <= {W{1'b0}};
            pd_req <= 1'b0;
        end else if (!idle || limit == {W{1'b0}}) begin
            // Zero limit disables power-down entry
            cnt_r <= {W{1'b0}};
            pd_req <= 1'b0;
        end else if (cnt_r >= limit) begin
            pd_req <= 1'b1;
        end else begin
            cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
        end
    end
endmodule

// ==== test/mcsr_top_checker.sv ====
// Purpose: Port-level assertions for the register block
// Assumes: Single clock, synchronous active-low reset
// Notes: Bound to every instance of the top module
`timescale 1ns/1ns
// ==========================================================
// Checker
module mcsr_top_checker (
    input wire clk,                      // Clock
    input wire rst_n,                    // Reset, active low
    input wire s_axi_awready,            // Write address ready
    input wire s_axi_wready,             // Write data ready
    input wire [1:0] s_axi_bresp,        // Write response
    input wire s_axi_bvalid,             // Write response valid
    input wire s_axi_bready,             // Write response ready
    input wire s_axi_arvalid,            // Read address valid
    input wire s_axi_arready,            // Read address ready
    input wire [31:0] s_axi_rdata,       // Read data
    input wire s_axi_rvalid,             // Read data valid
    input wire s_axi_rready,             // Read data ready
    input wire phy_cal_req,              // Calibration request
    input wire [5:0] mem_clk_disable,    // Clock disables
    input wire ctl_queue_empty,          // Idle level
    input wire local_self_rfsh_req,      // Local self-refresh request
    input wire powerdown_req,            // Power-down request
    input wire self_refresh_req,         // Self-refresh request
    input wire [1:0] addr_order,         // Address order
    input wire registered_module_enable  // Registered module support
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_wr_taken;
        s_axi_awready && s_axi_wready;
    endsequence
    a_rd_answer: assert property (s_rd_taken |-> ##[1:2] s_axi_rvalid)
        else $error("read not answered");
    a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_wr_answer: assert property (s_wr_taken |-> ##[1:3] s_axi_bvalid)
        else $error("write not answered");
    a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
    a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("address ready longer than one cycle");
    a_rd_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read valid not released after ready");
    a_wr_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not released after ready");
    // PHY and configuration outputs may only move as the result of a register write
    a_phy_by_write: assert property (($changed(phy_cal_req) || $changed(mem_clk_disable)) |-> ##[0:1] s_axi_bvalid)
        else $error("phy controls changed without write");
    a_cfg_by_write: assert property (($changed(addr_order) || $changed(registered_module_enable)) |-> ##[0:1] s_axi_bvalid)
        else $error("config outputs changed without write");
    a_sr_local: assert property (local_self_rfsh_req [*5] |-> self_refresh_req)
        else $error("local request did not reach self-refresh");
    a_pd_busy: assert property ((!ctl_queue_empty) [*4] |-> !powerdown_req)
        else $error("power-down while busy");
endmodule
bind mcsr_top mcsr_top_checker u_mcsr_chk (
    .clk(clk), .rst_n(rst_n), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .phy_cal_req(phy_cal_req),
    .mem_clk_disable(mem_clk_disable), .ctl_queue_empty(ctl_queue_empty),
    .local_self_rfsh_req(local_self_rfsh_req), .powerdown_req(powerdown_req),
    .self_refresh_req(self_refresh_req), .addr_order(addr_order),
    .registered_module_enable(registered_module_enable));

// ==== test/mcsr_mem_model.sv ====
// Purpose: Behavioural physical layer and memory state model
// Assumes: Calibration runs a fixed 8 cycles after the request drops
// Notes: fail_mode makes calibration end in failure
`timescale 1ns/1ns
module mcsr_mem_model (
    input wire clk,           // Clock
    input wire rst_n,         // Reset, active low
    input wire fail_mode,     // Calibration ends in failure
    input wire cal_req,       // Calibration request
    input wire pd_req,        // Power-down request
    input wire sr_req,        // Self-refresh request
    output reg cal_success = 1'b0, // Calibration passed
    output reg cal_fail = 1'b0,    // Calibration failed
    output reg in_pd = 1'b0,       // Memory in power-down
    output reg in_sr = 1'b0        // Memory in self-refresh
);
    reg req_d_r = 1'b0;
    reg [3:0] cnt_r = 4'h0;
    always @(posedge clk) begin
        req_d_r <= cal_req;
        in_pd <= pd_req & rst_n;
        in_sr <= sr_req & rst_n;
        if (!rst_n || cal_req) begin
            cal_success <= 1'b0;
            cal_fail <= 1'b0;
            cnt_r <= 4'h0;
        end else if (req_d_r) begin
            cnt_r <= 4'h8; // Sequence starts only once the request drops
        end else if (cnt_r == 4'h1) begin
            cal_success <= ~fail_mode;
            cal_fail <= fail_mode;
            cnt_r <= 4'h0;
        end else if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
        end
    end
endmodule

// ==== test/mcsr_top_tb_top.sv ====
// Purpose: Register-level self-checking bench
// Assumes: Default idle count reset value and half-rate code
// Notes: Every wait is bounded
`timescale 1ns/1ns
`include "mcsr_defs.vh"
module mcsr_top_tb_top;
    localparam [31:0] RATE = {7'h00, `MCSR_RATE_HALF, 23'h000000};
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg [13:0] awaddr = 14'h0000;
    reg [13:0] araddr = 14'h0000;
    reg [31:0] wdata = 32'h00000000;
    reg [3:0] wstrb = 4'hF;
    reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    reg idle = 1'b0, lsr = 1'b0, fmode = 1'b0;
    wire awready, wready, bvalid, arready, rvalid, cal_ok, cal_bad, cal_req;
    wire pd_req, sr_req, in_pd, in_sr, reg_mod, irq;
    wire [1:0] bresp, rresp, ord;
    wire [31:0] rdata;
    wire [5:0] clk_off;
    reg [31:0] rd_d;
    reg [1:0] rsp;
    integer fails = 0, checks_done = 0, i, n;
    mcsr_top dut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .phy_cal_success(cal_ok), .phy_cal_fail(cal_bad), .phy_cal_req(cal_req),
        .mem_clk_disable(clk_off), .ctl_queue_empty(idle), .local_self_rfsh_req(lsr),
        .mem_in_powerdown(in_pd), .mem_in_self_refresh(in_sr), .powerdown_req(pd_req),
        .self_refresh_req(sr_req), .addr_order(ord), .registered_module_enable(reg_mod),
        .irq(irq));
    mcsr_mem_model u_mem (.clk(clk), .rst_n(rst_n), .fail_mode(fmode), .cal_req(cal_req),
        .pd_req(pd_req), .sr_req(sr_req), .cal_success(cal_ok), .cal_fail(cal_bad),
        .in_pd(in_pd), .in_sr(in_sr));
    initial begin
        forever #5 clk = ~clk;
    end
    // ==========================================================
    // Tasks
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("[ERR] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks %0d errors %0d", checks_done, fails);
            if (fails == 0 && checks_done > 0) begin
                $display("TB: PASS");
            end else begin
                $display("TB: FAIL");
            end
            $finish;
        end
    endtask
    task limit(input integer k, input integer lim);
        begin
            if (k >= lim) begin
                fails = fails + 1;
                $display("[ERR] %0t wait timed out", $time);
                tally_and_finish;
            end
        end
    endtask
    task wr(input [13:0] a, input [31:0] d, input [3:0] s);
        begin
            @(posedge clk);
            awaddr <= a;
            wdata <= d;
            wstrb <= s;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            n = 0;
            do begin
                @(posedge clk);
                n = n + 1;
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
            end while (!bvalid && n < 60);
            bready <= 1'b0;
            rsp = bresp;
            limit(n, 60);
        end
    endtask
    task rd(input [13:0] a);
        begin
            @(posedge clk);
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            n = 0;
            do begin
                @(posedge clk);
                n = n + 1;
                if (arready) arvalid <= 1'b0;
            end while (!rvalid && n < 60);
            rready <= 1'b0;
            rd_d = rdata;
            rsp = rresp;
            limit(n, 60);
        end
    endtask
    // Software may touch the register again only once a result shows
    task poll_cal;
        begin
            i = 0;
            do begin
                rd(`MCSR_ADDR_PHY);
                i = i + 1;
            end while (rd_d[1:0] == 2'b00 && i < 30);
            limit(i, 30);
        end
    endtask
    // ==========================================================
    // Sequence
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rd(`MCSR_ADDR_PHY); chk(rd_d, 32'h0);
        rd(`MCSR_ADDR_CFG); chk(rd_d, RATE);
        rd(14'h03FC); chk({30'h0, rsp}, {30'h0, `MCSR_RESP_SLVERR});
        wr(14'h03FC, 32'hFFFFFFFF, 4'hF); chk({30'h0, rsp}, {30'h0, `MCSR_RESP_SLVERR});
        wr(`MCSR_ADDR_IRQ_MASK, 32'hF, 4'hF); chk({30'h0, rsp}, {30'h0, `MCSR_RESP_OKAY});
        wr(`MCSR_ADDR_PHY, 32'hFFFFFFFF, 4'hF);
        chk({31'h0, cal_req}, 32'h1);
        chk({26'h0, clk_off}, 32'h3F);
        rd(`MCSR_ADDR_PHY); chk(rd_d, 32'h3F04);
        wr(`MCSR_ADDR_PHY, 32'h3F00, 4'hF);
        poll_cal; chk(rd_d, 32'h3F01);
        // Status bit trails the synchronised level by one edge, interrupt by two
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        rd(`MCSR_ADDR_IRQ_STAT); chk(rd_d, 32'h1);
        wr(`MCSR_ADDR_IRQ_STAT, 32'h1, 4'hF);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        wr(`MCSR_ADDR_PHY, 32'h0, 4'hF); chk({26'h0, clk_off}, 32'h0);
        rd(`MCSR_ADDR_PHY); chk(rd_d, 32'h1);
        fmode <= 1'b1;
        wr(`MCSR_ADDR_PHY, 32'h4, 4'hF);
        wr(`MCSR_ADDR_PHY, 32'h0, 4'hF);
        poll_cal; chk(rd_d, 32'h2);
        rd(`MCSR_ADDR_IRQ_STAT); chk(rd_d, 32'h2);
        wr(`MCSR_ADDR_IRQ_MASK, 32'h0, 4'hF);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        wr(`MCSR_ADDR_IRQ_STAT, 32'hF, 4'hF);
        for (i = 0; i < 4; i = i + 1) begin
            wr(`MCSR_ADDR_CFG, {8'hFF, 2'b11, i[1:0], 4'hA, 16'h0}, 4'hF);
            repeat (2) @(posedge clk);
            chk({30'h0, ord}, {30'h0, i[1:0]});
            chk({31'h0, reg_mod}, 32'h1);
            chk({31'h0, sr_req}, 32'h1);
            repeat (3) @(posedge clk);
            rd(`MCSR_ADDR_CFG);
            chk(rd_d, RATE | {9'h0, 1'b1, i[1:0], 1'b0, 2'b11, 17'h0});
        end
        wr(`MCSR_ADDR_CFG, 32'h0, 4'hF);
        repeat (2) @(posedge clk);
        chk({31'h0, sr_req}, 32'h0);
        lsr <= 1'b1;
        repeat (6) @(posedge clk);
        chk({31'h0, sr_req}, 32'h1);
        lsr <= 1'b0;
        wr(`MCSR_ADDR_CFG, 32'hFFFFFF05, 4'h1);
        idle <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n = n + 1;
        end while (!pd_req && n < 40);
        chk({31'h0, n >= 5 && n <= 9}, 32'h1);
        repeat (4) @(posedge clk);
        rd(`MCSR_ADDR_CFG); chk(rd_d, RATE | 32'h10005);
        idle <= 1'b0;
        repeat (5) @(posedge clk);
        chk({31'h0, pd_req}, 32'h0);
        wr(`MCSR_ADDR_CFG, 32'h0, 4'hF);
        idle <= 1'b1;
        repeat (30) @(posedge clk);
        chk({31'h0, pd_req}, 32'h0);
        idle <= 1'b0;
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd(`MCSR_ADDR_CFG); chk(rd_d, RATE);
        tally_and_finish;
    end
endmodule
